// ==== rtl/nfc_host.sv ====
/*
  Controller for an 8-bit multiplexed NAND flash: issues command,
  address and data cycles on the flash pins and returns read bytes.
  Assumes the flash pins sit outside this clock domain (ready/busy is
  synchronised) and that the user sequences whole operations.
*/
// Summary of operation
// - full address goes out as two column then three row bytes
// - address bits packed A0-A30 over five cycles, unused bits low
// - reads and programs act on pages, erases on 4096 blocks
// - bytes latched on write strobe rising edge with chip select low
// - command select marks command, address select address, else data
// - reset and status reads are single command cycles
// - read, program, erase: setup command, address, execute command
// - erase address carries the three row cycles only
// - codes: read 00/30, program 80/10, erase 60/D0, id 90, reset FF
// - copy-back read 00/35, two-plane 60 60/35, copy program 85/10
// - copy-back with 2KB data: 85/11 then 85/10
// - program with 2KB data: 80/11 then 80/10; two-plane ends 81/10
// - two-plane random output: 00, 05 plus column, then E0
// - while busy only FF, 70, 7B and F1 are issued
// - between 11h and 80/81/85 only 70, F1 or FF allowed
// - error_detect_code status 7Bh only meaningful during copy-back
// - two-plane random output only after a two-plane read
// - random data input and output move the column within a page
// - only defined command codes are ever written
`timescale 1ns/1ps
`default_nettype none

module nfc_host
#(
  parameter int STROBE_LOW  = nfc_pkg::STROBE_LOW_CYC,
  parameter int STROBE_HIGH = nfc_pkg::STROBE_HIGH_CYC,
  parameter int ACCESS      = nfc_pkg::ACCESS_CYC
)
(
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  // user request side
  input  wire logic             REQ_VALID,
  output logic                  REQ_READY,
  input  wire nfc_pkg::nfc_req_t REQ,
  output logic                  REQ_REFUSED,
  // read data side
  output logic                  RD_VALID,
  input  wire logic             RD_READY,
  output nfc_pkg::nfc_word_t    RD_WORD,
  output logic                  FLASH_BUSY,
  // flash pins
  output logic                  CHIP_SEL_N,
  output logic                  CMD_SEL,
  output logic                  ADDR_SEL,
  output logic                  WRITE_STROBE_N,
  output logic                  READ_STROBE_N,
  output logic                  WRITE_PROT_N,
  input  wire logic [7:0]       IO_IN,
  output logic [7:0]            IO_OUT,
  output logic                  IO_OE,
  input  wire logic             READY_BUSY_N
);
  import nfc_pkg::*;

  // timing the sequencer cannot serve stops elaboration; an access of one
  // cycle would sample before the read strobe has fallen
  if (STROBE_LOW < 1 || STROBE_HIGH < 1 || ACCESS < 2 ||
      STROBE_LOW > 256 || STROBE_HIGH > 256 || ACCESS > STROBE_LOW + 1)
  begin : g_bad_timing
    $error("nfc_host: strobe timing parameters unusable");
  end

  typedef enum {
    S_IDLE,
    S_WR_LOW,
    S_WR_HIGH,
    S_RD_LOW,
    S_RD_HIGH
  } nfc_state_t;

  nfc_state_t        state;
  logic [7:0]        timer;
  logic [2:0]        cyc_idx;
  logic [2:0]        cyc_last;
  nfc_op_t           op;
  logic [ADDR_BITS-1:0] addr;
  logic [7:0]        wdata;
  logic [2:0]        rb_sync;
  logic              busy;
  logic              after_part;
  logic              plane2_read;
  logic              pend_plane2;
  logic              after_setup;
  logic              accept;
  logic              allowed;
  logic              push;
  logic              buf_ready;
  logic [7:0]        buf_data [2];
  logic              buf_full [2];
  logic              wr_ptr;
  logic              rd_ptr;

  // byte of the packed address for a given cycle
  function automatic logic [7:0] addr_byte(
    input logic [ADDR_BITS-1:0] a,
    input logic [2:0]           idx
  );
    logic [63:0] wide;
    wide = {33'h0_0000_0000, a};
    unique case (idx)
      3'h0: addr_byte = wide[7:0];
      3'h1: addr_byte = {3'h0, wide[12:8]};
      3'h2: addr_byte = wide[20:13];
      3'h3: addr_byte = wide[28:21];
      default: addr_byte = {6'h00, wide[30:29]};
    endcase
  endfunction

  // is a command code one of the defined set
  function automatic logic cmd_defined(input logic [7:0] c);
    unique case (c)
      CMD_READ_SETUP, CMD_READ_EXEC, CMD_READ_COPY, CMD_RAND_OUT,
      CMD_RAND_OUT_GO, CMD_PROG_SETUP, CMD_PROG_PLANE2, CMD_COPY_PROG,
      CMD_PROG_EXEC, CMD_PROG_PART, CMD_ERASE_SETUP, CMD_ERASE_EXEC,
      CMD_READ_ID, CMD_RESET, CMD_STATUS, CMD_EDC_STATUS,
      CMD_STATUS2: cmd_defined = 1'b1;
      default:     cmd_defined = 1'b0;
    endcase
  endfunction

  // commands the flash takes while busy (FF, 70, F1, 7B)
  function automatic logic cmd_always_ok(input logic [7:0] c);
    cmd_always_ok = (c == CMD_RESET) || (c == CMD_STATUS) ||
                    (c == CMD_STATUS2) || (c == CMD_EDC_STATUS);
  endfunction

  // ready/busy pin: three flops, change taken when last two agree
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rb_sync <= 3'h7;
    else
      rb_sync <= {rb_sync[1:0], READY_BUSY_N};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      busy <= 1'b0;
    else if (rb_sync[2] == rb_sync[1])
      busy <= ~rb_sync[2];
  end

  // request screening: only legal commands leave the controller
  always_comb
  begin
    allowed = 1'b1;
    if (REQ.op == NFC_OP_CMD)
    begin
      if (!cmd_defined(REQ.data))
        allowed = 1'b0;
      else if (busy && !cmd_always_ok(REQ.data))
        allowed = 1'b0;
      else if (after_part && REQ.data != CMD_STATUS &&
               REQ.data != CMD_STATUS2 && REQ.data != CMD_RESET &&
               REQ.data != CMD_PROG_SETUP &&
               REQ.data != CMD_PROG_PLANE2 &&
               REQ.data != CMD_COPY_PROG)
        allowed = 1'b0;
      else if (REQ.data == CMD_RAND_OUT && after_setup && !plane2_read)
        allowed = 1'b0;
    end
    else if (busy)
      allowed = 1'b0;
  end

  assign REQ_READY   = (state == S_IDLE) && buf_ready;
  assign accept      = REQ_VALID && REQ_READY && allowed;
  assign REQ_REFUSED = REQ_VALID && REQ_READY && !allowed;
  assign FLASH_BUSY  = busy;

  // command history: part programs and two-plane reads
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      after_part  <= 1'b0;
      plane2_read <= 1'b0;
      pend_plane2 <= 1'b0;
      after_setup <= 1'b0;
    end
    else if (accept && REQ.op == NFC_OP_CMD)
    begin
      // 00h directly ahead of 05h marks the two-plane output form
      after_setup <= (REQ.data == CMD_READ_SETUP);
      if (REQ.data == CMD_PROG_PART)
        after_part <= 1'b1;
      else if (REQ.data == CMD_PROG_SETUP || REQ.data == CMD_COPY_PROG ||
               REQ.data == CMD_PROG_PLANE2 || REQ.data == CMD_RESET)
        after_part <= 1'b0;
      // two-plane read is 60h 60h then 30h/35h
      if (REQ.data == CMD_ERASE_SETUP)
        pend_plane2 <= 1'b1;
      else if (REQ.data == CMD_READ_SETUP)
        pend_plane2 <= plane2_read;
      else if (REQ.data != CMD_RAND_OUT)
        pend_plane2 <= 1'b0;
      if (pend_plane2 && (REQ.data == CMD_READ_EXEC ||
                          REQ.data == CMD_READ_COPY))
        plane2_read <= 1'b1;
      else if (REQ.data == CMD_PROG_SETUP || REQ.data == CMD_RESET ||
               REQ.data == CMD_ERASE_EXEC)
        plane2_read <= 1'b0;
    end
  end

  // request capture and cycle count of address sequences
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      op       <= NFC_OP_CMD;
      addr     <= '0;
      wdata    <= 8'h00;
      cyc_idx  <= 3'h0;
      cyc_last <= 3'h0;
    end
    else if (accept)
    begin
      op    <= REQ.op;
      addr  <= REQ.addr;
      wdata <= REQ.data;
      unique case (REQ.op)
        NFC_OP_ADDR_FULL:
        begin
          cyc_idx  <= 3'h0;
          cyc_last <= 3'h4;
        end
        NFC_OP_ADDR_ROW:
        begin
          cyc_idx  <= 3'(COL_CYCLES);
          cyc_last <= 3'h4;
        end
        NFC_OP_ADDR_COL:
        begin
          cyc_idx  <= 3'h0;
          cyc_last <= 3'(COL_CYCLES - 1);
        end
        default:
        begin
          cyc_idx  <= 3'h0;
          cyc_last <= 3'h0;
        end
      endcase
    end
    else if (state == S_WR_HIGH && timer == 8'h00 && cyc_idx != cyc_last)
      cyc_idx <= cyc_idx + 3'h1;
  end

  // strobe sequencer
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state <= S_IDLE;
      timer <= 8'h00;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (accept)
          begin
            state <= (REQ.op == NFC_OP_READ) ? S_RD_LOW : S_WR_LOW;
            timer <= 8'(STROBE_LOW - 1);
          end
        S_WR_LOW:
          if (timer == 8'h00)
          begin
            state <= S_WR_HIGH;
            timer <= 8'(STROBE_HIGH - 1);
          end
          else
            timer <= timer - 8'h01;
        S_WR_HIGH:
          if (timer == 8'h00)
          begin
            state <= (cyc_idx != cyc_last) ? S_WR_LOW : S_IDLE;
            timer <= 8'(STROBE_LOW - 1);
          end
          else
            timer <= timer - 8'h01;
        S_RD_LOW:
          if (timer == 8'h00)
          begin
            state <= S_RD_HIGH;
            timer <= 8'(STROBE_HIGH - 1);
          end
          else
            timer <= timer - 8'h01;
        S_RD_HIGH:
          if (timer == 8'h00)
            state <= S_IDLE;
          else
            timer <= timer - 8'h01;
      endcase
    end
  end

  // pin drivers, registered so the bus is glitch free
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      CHIP_SEL_N     <= 1'b1;
      CMD_SEL        <= 1'b0;
      ADDR_SEL       <= 1'b0;
      WRITE_STROBE_N <= 1'b1;
      READ_STROBE_N  <= 1'b1;
      IO_OUT         <= 8'h00;
      IO_OE          <= 1'b0;
      WRITE_PROT_N   <= 1'b0;
    end
    else
    begin
      WRITE_PROT_N   <= 1'b1;
      CHIP_SEL_N     <= (state == S_IDLE) && !accept;
      WRITE_STROBE_N <= !(state == S_WR_LOW);
      READ_STROBE_N  <= !(state == S_RD_LOW);
      IO_OE          <= (state == S_WR_LOW) || (state == S_WR_HIGH);
      CMD_SEL        <= (op == NFC_OP_CMD) && (state != S_IDLE);
      ADDR_SEL       <= (op == NFC_OP_ADDR_FULL || op == NFC_OP_ADDR_ROW ||
                         op == NFC_OP_ADDR_COL) && (state != S_IDLE);
      if (op == NFC_OP_CMD || op == NFC_OP_WRITE)
        IO_OUT <= wdata;
      else
        IO_OUT <= addr_byte(addr, cyc_idx);
    end
  end

  // sample ACCESS edges after the accept; past the low phase that is the
  // last edge before the strobe rises, so the byte still stands
  assign push = (ACCESS <= STROBE_LOW) ?
                ((state == S_RD_LOW) && (timer == 8'(STROBE_LOW - ACCESS))) :
                ((state == S_RD_HIGH) && (timer == 8'(STROBE_HIGH - 1)));

  // two-entry read buffer; request side stalls while it is full
  assign buf_ready = !(buf_full[0] && buf_full[1]);
  assign RD_VALID  = buf_full[rd_ptr];
  assign RD_WORD   = '{data: buf_data[rd_ptr]};

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (RD_VALID && RD_READY)
        rd_ptr <= ~rd_ptr;
    end
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_buf
    always_ff @(posedge REF_CLK)
    begin
      if (RST)
      begin
        buf_full[i] <= 1'b0;
        buf_data[i] <= 8'h00;
      end
      else if (push && wr_ptr == 1'(i))
      begin
        buf_full[i] <= 1'b1;
        buf_data[i] <= IO_IN;
      end
      else if (RD_VALID && RD_READY && rd_ptr == 1'(i))
        buf_full[i] <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/nfc_pkg.sv ====
/*
  Package for the NAND flash bus controller: command codes, address
  cycle layout, page geometry and pin timing counts.
  Assumes a 100 MHz controller clock and an 8-bit multiplexed flash bus.
*/
package nfc_pkg;

  // command codes
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_EXEC    = 8'h30;
  localparam logic [7:0] CMD_READ_COPY    = 8'h35;
  localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_GO  = 8'hE0;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
  localparam logic [7:0] CMD_PROG_PLANE2  = 8'h81;
  localparam logic [7:0] CMD_COPY_PROG    = 8'h85;
  localparam logic [7:0] CMD_PROG_EXEC    = 8'h10;
  localparam logic [7:0] CMD_PROG_PART    = 8'h11;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_EXEC   = 8'hD0;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_RESET        = 8'hFF;
  localparam logic [7:0] CMD_STATUS       = 8'h70;
  localparam logic [7:0] CMD_EDC_STATUS   = 8'h7B;
  localparam logic [7:0] CMD_STATUS2      = 8'hF1;

  // address geometry
  localparam int ADDR_BITS      = 31;
  localparam int COL_BITS       = 13;
  localparam int ROW_BITS       = 18;
  localparam int COL_CYCLES     = 2;
  localparam int ROW_CYCLES     = 3;
  localparam int PAGE_BYTES     = 4224;
  localparam int SPARE_START    = 4096;
  localparam int BLOCK_COUNT    = 4096;

  // strobe timing, in ns, and derived cycle counts at 100 MHz
  localparam int CLK_NS         = 10;
  localparam int STROBE_LOW_NS  = 20;
  localparam int STROBE_HIGH_NS = 20;
  localparam int ACCESS_NS      = 30;
  localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC      = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

  // kinds of bus cycle the user may request
  typedef enum logic [2:0] {
    NFC_OP_CMD,
    NFC_OP_ADDR_FULL,
    NFC_OP_ADDR_ROW,
    NFC_OP_ADDR_COL,
    NFC_OP_WRITE,
    NFC_OP_READ
  } nfc_op_t;

  typedef struct packed {
    nfc_op_t                 op;
    logic [7:0]              data;
    logic [ADDR_BITS-1:0]    addr;
  } nfc_req_t;

  typedef struct packed {
    logic [7:0] data;
  } nfc_word_t;

endpackage

// ==== test/nfc_checker.sv ====
/* nfc_checker: pin and handshake assertions for nfc_host.
   Assumes one clock domain and the default strobe counts. */
`timescale 1ns/1ps
`default_nettype none
module nfc_checker
(
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       RD_VALID,
  input wire logic       FLASH_BUSY,
  input wire logic       CHIP_SEL_N,
  input wire logic       CMD_SEL,
  input wire logic       ADDR_SEL,
  input wire logic       WRITE_STROBE_N,
  input wire logic       READ_STROBE_N,
  input wire logic [7:0] IO_OUT,
  input wire logic       IO_OE,
  input wire logic       READY_BUSY_N
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // second low cycle, then the latching rise
  sequence s_we_end;
    !WRITE_STROBE_N ##1 WRITE_STROBE_N;
  endsequence
  a_we_width:
    assert property ($fell(WRITE_STROBE_N) |=> s_we_end)
    else $error("write strobe width wrong");
  a_we_select:
    assert property (!WRITE_STROBE_N |-> !CHIP_SEL_N && IO_OE)
    else $error("write strobe without select");
  a_sel_onehot:
    assert property (!(CMD_SEL && ADDR_SEL))
    else $error("both latch selects high");
  a_latch_stable:
    assert property ($rose(WRITE_STROBE_N) |->
      $stable(IO_OUT) && $stable(CMD_SEL) && $stable(ADDR_SEL))
    else $error("bus moved under write strobe");
  a_busy_codes:
    assert property ($rose(WRITE_STROBE_N) && CMD_SEL && FLASH_BUSY
      |-> IO_OUT inside {8'hFF, 8'h70, 8'h7B, 8'hF1})
    else $error("command not allowed while busy");
  a_codes_known:
    assert property ($rose(WRITE_STROBE_N) && CMD_SEL |-> IO_OUT inside
      {8'h00, 8'h30, 8'h35, 8'h05, 8'hE0, 8'h80, 8'h81, 8'h85, 8'h10,
       8'h11, 8'h60, 8'hD0, 8'h90, 8'hFF, 8'h70, 8'h7B, 8'hF1})
    else $error("undefined command on bus");
  a_read_idle:
    assert property (!READ_STROBE_N |-> !IO_OE && !CHIP_SEL_N)
    else $error("read strobe with bus driven");
  a_read_return:
    assert property ($fell(READ_STROBE_N) |-> ##[2:5] RD_VALID)
    else $error("read byte not returned");
  a_busy_sync:
    assert property (!READY_BUSY_N [*6] |-> FLASH_BUSY)
    else $error("busy pin not reflected");
endmodule
bind nfc_host nfc_checker chk_u (
  .REF_CLK(REF_CLK), .RST(RST), .RD_VALID(RD_VALID),
  .FLASH_BUSY(FLASH_BUSY), .CHIP_SEL_N(CHIP_SEL_N), .CMD_SEL(CMD_SEL),
  .ADDR_SEL(ADDR_SEL), .WRITE_STROBE_N(WRITE_STROBE_N),
  .READ_STROBE_N(READ_STROBE_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
  .READY_BUSY_N(READY_BUSY_N));
`default_nettype wire

// ==== test/nfc_flash_model.sv ====
/* nfc_flash_model: behavioural flash device that logs latched bytes.
   Assumes the controller keeps the strobe timing. */
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model
#(
  parameter int BUSY_NS = 2000
)
(
  input  wire logic       chip_sel_n,
  input  wire logic       cmd_sel,
  input  wire logic       addr_sel,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] io_out,
  output wire logic [7:0] io_in,
  output wire logic       ready_busy_n
);
  logic [9:0]  log_q[$];
  logic [12:0] col = 13'h0000;
  logic [7:0]  dout = 8'h00;
  logic        rb = 1'b1;
  int          n_addr = 0;
  // released bus shows the inverse so stale data never matches
  assign ready_busy_n = rb;
  assign io_in = (!read_strobe_n && !chip_sel_n) ? dout : ~dout;
  // bytes latch on the rising write strobe while selected
  always @(posedge write_strobe_n)
  begin
    if (!chip_sel_n)
    begin
      log_q.push_back({cmd_sel, addr_sel, io_out});
      if (cmd_sel)
      begin
        n_addr = (io_out == 8'h60) ? 2 : 0;
        if (io_out inside {8'h30, 8'h35, 8'h10, 8'hD0})
        begin
          rb <= 1'b0;
          rb <= #BUSY_NS 1'b1;
        end
      end
      else if (addr_sel && n_addr < 5)
      begin
        if (n_addr == 0)
          col[7:0] = io_out;
        if (n_addr == 1)
          col[12:8] = io_out[4:0];
        n_addr++;
      end
    end
  end
  // byte shows shortly after the falling read strobe, column steps on
  always @(negedge read_strobe_n)
  begin
    if (!chip_sel_n)
    begin
      dout <= #5 col[7:0] ^ 8'hA5;
      col = (col == 13'h107F) ? '0 : col + 13'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
/* testbench: drives nfc_host against the flash model, checks the bus
   log and read bytes. Assumes the package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nfc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       req_valid = 1'b0;
  logic       rd_ready = 1'b0;
  nfc_req_t   req = '0;
  nfc_word_t  rd_word;
  logic       req_ready, req_refused, rd_valid, flash_busy, refused;
  logic       cs_n, cmd_sel, addr_sel, we_n, re_n, io_oe, rb_n, wp_n;
  logic [7:0] io_in, io_out;
  int         err_total = 0;
  int         n_checks = 0;
  int         pos = 0;
  always #5 ref_clk = ~ref_clk;
  nfc_host dut_u (
    .REF_CLK(ref_clk), .RST(rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ(req), .REQ_REFUSED(req_refused),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_WORD(rd_word),
    .FLASH_BUSY(flash_busy), .CHIP_SEL_N(cs_n), .CMD_SEL(cmd_sel),
    .ADDR_SEL(addr_sel), .WRITE_STROBE_N(we_n), .READ_STROBE_N(re_n),
    .WRITE_PROT_N(wp_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe),
    .READY_BUSY_N(rb_n));
  nfc_flash_model m_u (
    .chip_sel_n(cs_n), .cmd_sel(cmd_sel), .addr_sel(addr_sel),
    .write_strobe_n(we_n), .read_strobe_n(re_n), .io_out(io_out),
    .io_in(io_in), .ready_busy_n(rb_n));
  task chk(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hold the offer until the accepting edge; ready is stable mid-cycle
  task send(input nfc_op_t op, input logic [7:0] d, input logic [30:0] a);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{op, d, a};
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (!req_ready && n < 500);
    chk(10'(req_ready), 10'h001);
    refused = req_refused;
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  task cmd(input logic [7:0] c);
    send(NFC_OP_CMD, c, 31'h0000_0000);
  endtask
  task ck_log(input logic [9:0] e);
    chk(m_u.log_q[pos], e);
    pos++;
  endtask
  // expected bus byte i of a full address
  function automatic logic [7:0] ab(input logic [30:0] a, input int i);
    case (i)
      0: ab = a[7:0];
      1: ab = {3'h0, a[12:8]};
      2: ab = a[20:13];
      3: ab = a[28:21];
      default: ab = {6'h00, a[30:29]};
    endcase
  endfunction
  task wait_busy;
    int   n;
    logic seen;
    seen = 1'b0;
    for (n = 0; n < 600 && !(seen && !flash_busy); n++)
    begin
      @(negedge ref_clk);
      seen = seen | flash_busy;
    end
    chk(10'(seen), 10'h001);
  endtask
  task pop(input logic [7:0] e);
    int n;
    @(posedge ref_clk);
    rd_ready <= 1'b1;
    for (n = 0; n < 50 && !rd_valid; n++)
      @(negedge ref_clk);
    chk(10'(rd_valid), 10'h001);
    chk({2'b00, rd_word.data}, {2'b00, e});
    @(posedge ref_clk);
    rd_ready <= 1'b0;
  endtask
  // erase, then commands offered while the array is busy
  task t_erase;
    int n;
    cmd(CMD_ERASE_SETUP);
    send(NFC_OP_ADDR_ROW, 8'h00, 31'h2345_6789);
    cmd(CMD_ERASE_EXEC);
    for (n = 0; n < 50 && !flash_busy; n++)
      @(negedge ref_clk);
    cmd(CMD_READ_SETUP);
    chk(10'(refused), 10'h001);
    cmd(CMD_STATUS);
    chk(10'(refused), 10'h000);
    wait_busy();
    ck_log({2'b10, CMD_ERASE_SETUP});
    for (n = 2; n < 5; n++)
      ck_log({2'b01, ab(31'h2345_6789, n)});
    ck_log({2'b10, CMD_ERASE_EXEC});
    ck_log({2'b10, CMD_STATUS});
  endtask
  // read across the main/spare boundary with the consumer stalled
  task t_read;
    int n;
    cmd(CMD_READ_SETUP);
    send(NFC_OP_ADDR_FULL, 8'h00, 31'h1234_4FFF);
    cmd(CMD_READ_EXEC);
    wait_busy();
    send(NFC_OP_READ, 8'h00, 31'h0000_0000);
    send(NFC_OP_READ, 8'h00, 31'h0000_0000);
    repeat (8) @(negedge ref_clk);
    chk(10'(req_ready), 10'h000);
    pop(8'h5A);
    pop(8'hA5);
    send(NFC_OP_READ, 8'h00, 31'h0000_0000);
    pop(8'hA4);
    ck_log({2'b10, CMD_READ_SETUP});
    for (n = 0; n < 5; n++)
      ck_log({2'b01, ab(31'h1234_4FFF, n)});
    ck_log({2'b10, CMD_READ_EXEC});
  endtask
  task t_prog;
    int n;
    cmd(CMD_PROG_SETUP);
    send(NFC_OP_ADDR_FULL, 8'h00, 31'h0ABC_1000);
    send(NFC_OP_WRITE, 8'h3C, 31'h0000_0000);
    send(NFC_OP_WRITE, 8'hC3, 31'h0000_0000);
    cmd(CMD_PROG_EXEC);
    wait_busy();
    ck_log({2'b10, CMD_PROG_SETUP});
    for (n = 0; n < 5; n++)
      ck_log({2'b01, ab(31'h0ABC_1000, n)});
    ck_log({2'b00, 8'h3C});
    ck_log({2'b00, 8'hC3});
    ck_log({2'b10, CMD_PROG_EXEC});
  endtask
  // codes and orders that must be turned away, and those allowed after 11h
  task t_refuse;
    cmd(8'h42);
    chk(10'(refused), 10'h001);
    cmd(CMD_READ_SETUP);
    cmd(CMD_RAND_OUT);
    chk(10'(refused), 10'h001);
    cmd(CMD_RESET);
    cmd(CMD_PROG_PART);
    cmd(CMD_READ_SETUP);
    chk(10'(refused), 10'h001);
    cmd(CMD_STATUS2);
    chk(10'(refused), 10'h000);
    cmd(CMD_PROG_SETUP);
    chk(10'(refused), 10'h000);
    cmd(CMD_RESET);
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    chk(10'(wp_n), 10'h000);
    rst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(10'(wp_n), 10'h001);
    t_erase();
    t_read();
    t_prog();
    t_refuse();
    complete_run();
  end
  // cuts a hung handshake short
  initial
  begin
    #200_000;
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
